// ### rtl/touch_timing_defines.svh
/*
 * Constants of the touch timing configuration block: register offsets,
 * reset values, field positions and timing figures.
 * Assumes a 200 MHz core clock; included by bare name.
 */
`ifndef TOUCH_TIMING_DEFINES_SVH
`define TOUCH_TIMING_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_ACTIVE_INPUT_ENABLE 8'h21
`define ADDR_TOUCH_TIMING_CONFIG 8'h22
`define ADDR_PRESS_HOLD_THRESHOLD 8'h23
`define ADDR_AVERAGING_SAMPLING 8'h24

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ACTIVE_INPUT_ENABLE 3'h7
`define RST_MAX_TOUCH_DURATION 4'hA
`define RST_REPEAT_INTERVAL 4'h4
`define RST_PRESS_HOLD 4'h7
`define RST_AVERAGING_SAMPLING 7'h39

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LONG_TOUCH_MSB 7
`define LONG_TOUCH_LSB 4
`define RPT_MSB 3
`define RPT_LSB 0
`define COUNT_CODE_MSB 6
`define COUNT_CODE_LSB 4
`define SAMP_MSB 3
`define SAMP_LSB 2
`define CYC_MSB 1
`define CYC_LSB 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define SAMPLE_BASE_NS 320000
`define STEP_MS 35
`define NUM_INPUTS 3

`endif

// ### rtl/touch_timing_pkg.sv
/*
 * Types shared by the touch timing configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package touch_timing_pkg;
    // Measurement sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SAMPLE,
        SEQ_STEP
    } seq_state_type;
    // Per-input millisecond duration
    typedef logic [13:0] dur_ms_type;
endpackage

// ### rtl/touch_duration_timer.sv
/*
 * Per-input touch duration timer: classifies touch versus press-and-hold,
 * paces auto-repeat and requests recalibration on an over-long touch.
 * Assumes a one-cycle millisecond tick and a same-clock touch level.
 */
`timescale 1ns/1ps
`default_nettype none
module touch_duration_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic ms_tick,
    input wire logic touching,
    input wire logic repeat_enable,
    input wire logic recal_enable,
    input wire touch_timing_pkg::dur_ms_type hold_ms,
    input wire touch_timing_pkg::dur_ms_type repeat_ms,
    input wire touch_timing_pkg::dur_ms_type max_ms,
    output logic touch_event_q,
    output logic hold_event_q,
    output logic repeat_event_q,
    output logic recal_request_q
);
    import touch_timing_pkg::*;

    dur_ms_type dur_q;   // Touch length so far
    dur_ms_type rpt_q;   // Time since last repeat
    logic hold_q;        // Touch classed as press-and-hold
    logic at_hold;       // Threshold passed on this tick
    assign at_hold = touching && ms_tick && repeat_enable && !hold_q && dur_q == hold_ms;

    // Duration counter, saturating, cleared on release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dur_q <= '0;
        end else if (!touching) begin
            dur_q <= '0;
        end else if (ms_tick && dur_q != '1) begin
            dur_q <= dur_q + 14'h1;
        end
    end

    // Hold classification
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b0;
            hold_event_q <= 1'b0;
        end else begin
            hold_event_q <= at_hold;
            if (!touching) begin
                hold_q <= 1'b0;
            end else if (at_hold) begin
                hold_q <= 1'b1;
            end
        end
    end

    // Ordinary touch reported at release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            touch_event_q <= 1'b0;
        end else begin
            touch_event_q <= !touching && dur_q != '0 && !hold_q;
        end
    end

    // Auto-repeat spacing while held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rpt_q <= '0;
            repeat_event_q <= 1'b0;
        end else begin
            repeat_event_q <= 1'b0;
            if (!hold_q || !touching) begin
                rpt_q <= '0;
            end else if (ms_tick) begin
                if (rpt_q == repeat_ms - 14'h1) begin
                    rpt_q <= '0;
                    repeat_event_q <= 1'b1;
                end else begin
                    rpt_q <= rpt_q + 14'h1;
                end
            end
        end
    end

    // Recalibration once the maximum duration is passed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            recal_request_q <= 1'b0;
        end else begin
            recal_request_q <= recal_enable && touching && ms_tick && dur_q == max_ms;
        end
    end

    chk_hold_after_threshold: assert property (@(posedge clk) disable iff (rst) at_hold |=> hold_event_q)
        else $error("hold event missing after threshold");
    chk_touch_not_hold: assert property (@(posedge clk) disable iff (rst)
        touch_event_q |-> $past(dur_q, 1) <= hold_ms || !$past(repeat_enable, 1))
        else $error("touch event after hold threshold");
    chk_recal_gated: assert property (@(posedge clk) disable iff (rst)
        recal_request_q |-> $past(recal_enable, 1) && $past(dur_q, 1) == max_ms)
        else $error("recalibration without enable or at wrong time");
endmodule
`default_nettype wire

// ### rtl/touch_timing_config.sv
/*
 * Touch timing configuration block: four host registers, the Active-state
 * measurement sequencer and three per-input duration timers.
 * Assumes register strobes and sample data come from same-clock logic.
 */
// Behaviour
// - enable bits include or skip each input
// - max-duration code picks recalibration time
// - repeat interval is (code+1) times 35 ms
// - longer than threshold is press-and-hold (code: only where repeat_enable is set, else a touch)
// - threshold is (code+1) times 35 ms
// - averaging code gives 2^code samples
// - samples back to back, one update
// - sample-time code picks sample duration
// - settings apply Active inputs, reset 39h
// - recalibrate over-long touch only when enabled
// - cycle time 35 to 140 ms
`timescale 1ns/1ps
`default_nettype none
`include "touch_timing_defines.svh"
module touch_timing_config #(
    parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
    parameter int SAMPLE_BASE_CYCLES = `SAMPLE_BASE_NS / `CLK_PERIOD_NS,
    parameter int SAMPLE_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    input wire logic long_touch_recal_enable,
    input wire logic [2:0] repeat_enable,
    input wire logic [2:0] touch_detect,
    input wire logic [SAMPLE_WIDTH-1:0] sample_value,
    output logic sampling_active_q,
    output logic [1:0] sample_channel_q,
    output logic meas_valid_q,
    output logic [1:0] meas_channel_q,
    output logic [SAMPLE_WIDTH-1:0] meas_result_q,
    output logic [2:0] touch_event_q,
    output logic [2:0] hold_event_q,
    output logic [2:0] repeat_event_q,
    output logic [2:0] recal_request_q
);
    import touch_timing_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [2:0] active_enable_q;       // Per-input Active enables
    logic [3:0] max_touch_duration_q;  // Recalibration time code
    logic [3:0] repeat_interval_q;     // Repeat spacing code
    logic [3:0] press_hold_q;          // Press-hold threshold code
    logic [6:0] meas_cfg_q;            // Averaging, sample and cycle codes

    // Host writes; undefined bits dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_enable_q <= `RST_ACTIVE_INPUT_ENABLE;
            max_touch_duration_q <= `RST_MAX_TOUCH_DURATION;
            repeat_interval_q <= `RST_REPEAT_INTERVAL;
            press_hold_q <= `RST_PRESS_HOLD;
            meas_cfg_q <= `RST_AVERAGING_SAMPLING;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_ACTIVE_INPUT_ENABLE: active_enable_q <= reg_wdata[2:0];
                `ADDR_TOUCH_TIMING_CONFIG: begin
                    max_touch_duration_q <= reg_wdata[`LONG_TOUCH_MSB:`LONG_TOUCH_LSB];
                    repeat_interval_q <= reg_wdata[`RPT_MSB:`RPT_LSB];
                end
                `ADDR_PRESS_HOLD_THRESHOLD: press_hold_q <= reg_wdata[3:0];
                `ADDR_AVERAGING_SAMPLING: meas_cfg_q <= reg_wdata[6:0];
                default: begin
                end
            endcase
        end
    end

    // Registered read data; unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_ACTIVE_INPUT_ENABLE: reg_rdata_q <= {5'h00, active_enable_q};
                `ADDR_TOUCH_TIMING_CONFIG: reg_rdata_q <= {max_touch_duration_q, repeat_interval_q};
                `ADDR_PRESS_HOLD_THRESHOLD: reg_rdata_q <= {4'h0, press_hold_q};
                `ADDR_AVERAGING_SAMPLING: reg_rdata_q <= {1'b0, meas_cfg_q};
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [17:0] tick_cnt_q; // Clock cycles within a millisecond
    logic ms_tick;
    assign ms_tick = tick_cnt_q == 18'(MS_CYCLES - 1);

    // Free-running prescaler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= '0;
        end else if (ms_tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 18'h1;
        end
    end

    // ----------------------------------------
    // Decoded times in milliseconds
    // ----------------------------------------
    dur_ms_type hold_ms;    // Press-hold threshold
    dur_ms_type repeat_ms;  // Repeat spacing
    dur_ms_type max_ms;     // Recalibration time
    dur_ms_type cycle_ms;   // Sensing cycle length
    assign hold_ms = 14'({press_hold_q} + 5'h1) * 14'(`STEP_MS);
    assign repeat_ms = 14'({repeat_interval_q} + 5'h1) * 14'(`STEP_MS);
    assign cycle_ms = 14'({meas_cfg_q[`CYC_MSB:`CYC_LSB]} + 3'h1) * 14'(`STEP_MS);

    // Maximum duration lookup
    always_comb begin
        case (max_touch_duration_q)
            4'h0: max_ms = 14'd560;
            4'h1: max_ms = 14'd840;
            4'h2: max_ms = 14'd1120;
            4'h3: max_ms = 14'd1400;
            4'h4: max_ms = 14'd1680;
            4'h5: max_ms = 14'd2240;
            4'h6: max_ms = 14'd2800;
            4'h7: max_ms = 14'd3360;
            4'h8: max_ms = 14'd3920;
            4'h9: max_ms = 14'd4480;
            4'hA: max_ms = 14'd5600;
            4'hB: max_ms = 14'd6720;
            4'hC: max_ms = 14'd7840;
            4'hD: max_ms = 14'd8906;
            4'hE: max_ms = 14'd10080;
            default: max_ms = 14'd11200;
        endcase
    end

    // ----------------------------------------
    // Per-input duration timers
    // ----------------------------------------
    for (genvar i = 0; i < `NUM_INPUTS; i++) begin : g_timer
        touch_duration_timer i_touch_duration_timer (
            .clk(clk),
            .rst(rst),
            .ms_tick(ms_tick),
            .touching(touch_detect[i]),
            .repeat_enable(repeat_enable[i]),
            .recal_enable(long_touch_recal_enable),
            .hold_ms(hold_ms),
            .repeat_ms(repeat_ms),
            .max_ms(max_ms),
            .touch_event_q(touch_event_q[i]),
            .hold_event_q(hold_event_q[i]),
            .repeat_event_q(repeat_event_q[i]),
            .recal_request_q(recal_request_q[i])
        );
    end

    // ----------------------------------------
    // Measurement sequencer
    // ----------------------------------------
    seq_state_type state_q;      // Sequencer state
    dur_ms_type cyc_elapsed_q;   // Time since cycle start
    logic [2:0] count_code_q;    // Averaging code for this cycle
    logic [1:0] samp_lat_q;      // Sample-time code for this cycle
    logic [19:0] samp_timer_q;   // Cycles within one sample
    logic [6:0] samp_count_q;    // Samples taken on this channel
    logic [SAMPLE_WIDTH+6:0] acc_q; // Running sum
    logic [19:0] sample_cycles;  // Length of one sample
    logic sample_end;            // Last cycle of a sample
    logic last_sample;           // Sample that completes a measurement
    logic start_due;             // Cycle time reached
    logic next_found;            // Another enabled channel follows
    logic [1:0] next_chan;       // That channel
    logic [SAMPLE_WIDTH+6:0] sum_full;

    assign sample_cycles = 20'(SAMPLE_BASE_CYCLES) << samp_lat_q;
    assign sample_end = samp_timer_q == sample_cycles - 20'h1;
    assign last_sample = samp_count_q == 7'((8'h1 << count_code_q) - 8'h1);
    assign start_due = cyc_elapsed_q >= cycle_ms;
    assign sum_full = acc_q + (SAMPLE_WIDTH+7)'(sample_value);

    // Next enabled channel after the current one
    always_comb begin
        next_found = 1'b0;
        next_chan = 2'h0;
        for (int k = `NUM_INPUTS - 1; k >= 0; k--) begin
            if (active_enable_q[k] && k > int'(sample_channel_q)) begin
                next_found = 1'b1;
                next_chan = 2'(k);
            end
        end
    end

    // Cycle timer; extended while sampling runs long
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_elapsed_q <= '0;
        end else if (state_q == SEQ_IDLE && start_due) begin
            cyc_elapsed_q <= '0;
        end else if (ms_tick && !start_due) begin
            cyc_elapsed_q <= cyc_elapsed_q + 14'h1;
        end
    end

    // State, channel and sample pacing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= SEQ_IDLE;
            sample_channel_q <= 2'h0;
            sampling_active_q <= 1'b0;
            count_code_q <= 3'h0;
            samp_lat_q <= 2'h0;
            samp_timer_q <= '0;
            samp_count_q <= '0;
        end else begin
            case (state_q)
                SEQ_IDLE: begin
                    // Start a cycle at the lowest enabled input
                    if (start_due && active_enable_q != 3'h0) begin
                        state_q <= SEQ_SAMPLE;
                        sample_channel_q <= active_enable_q[0] ? 2'h0 : (active_enable_q[1] ? 2'h1 : 2'h2);
                        sampling_active_q <= 1'b1;
                        count_code_q <= meas_cfg_q[`COUNT_CODE_MSB:`COUNT_CODE_LSB];
                        samp_lat_q <= meas_cfg_q[`SAMP_MSB:`SAMP_LSB];
                        samp_timer_q <= '0;
                        samp_count_q <= '0;
                    end
                end
                SEQ_SAMPLE: begin
                    // Back-to-back samples on one channel
                    if (!sample_end) begin
                        samp_timer_q <= samp_timer_q + 20'h1;
                    end else if (last_sample) begin
                        state_q <= SEQ_STEP;
                        sampling_active_q <= 1'b0;
                    end else begin
                        samp_timer_q <= '0;
                        samp_count_q <= samp_count_q + 7'h1;
                    end
                end
                SEQ_STEP: begin
                    // Move on or finish the cycle
                    samp_timer_q <= '0;
                    samp_count_q <= '0;
                    if (next_found) begin
                        state_q <= SEQ_SAMPLE;
                        sample_channel_q <= next_chan;
                        sampling_active_q <= 1'b1;
                    end else begin
                        state_q <= SEQ_IDLE;
                    end
                end
                default: state_q <= SEQ_IDLE;
            endcase
        end
    end

    // Accumulate and publish one average per channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
            meas_valid_q <= 1'b0;
            meas_channel_q <= 2'h0;
            meas_result_q <= '0;
        end else begin
            meas_valid_q <= 1'b0;
            if (state_q != SEQ_SAMPLE) begin
                acc_q <= '0;
            end else if (sample_end) begin
                acc_q <= sum_full;
                if (last_sample) begin
                    meas_valid_q <= 1'b1;
                    meas_channel_q <= sample_channel_q;
                    meas_result_q <= SAMPLE_WIDTH'(sum_full >> count_code_q);
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_last_sample;
        state_q == SEQ_SAMPLE && sample_end && last_sample;
    endsequence
    sequence s_publish;
        meas_valid_q ##1 !meas_valid_q;
    endsequence

    chk_skip_disabled: assert property (@(posedge clk) disable iff (rst)
        $rose(sampling_active_q) |-> ($past(active_enable_q, 1) & (3'h1 << sample_channel_q)) != 3'h0)
        else $error("disabled input sampled");
    chk_single_update: assert property (@(posedge clk) disable iff (rst) s_last_sample |=> s_publish)
        else $error("measurement not published exactly once");
    chk_update_cause: assert property (@(posedge clk) disable iff (rst)
        meas_valid_q |-> $past(state_q, 1) == SEQ_SAMPLE && $past(last_sample, 1))
        else $error("result updated mid-measurement");
    chk_sample_count: assert property (@(posedge clk) disable iff (rst)
        state_q == SEQ_SAMPLE |-> {1'b0, samp_count_q} < (8'h1 << count_code_q))
        else $error("sample count beyond averaging setting");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `ADDR_ACTIVE_INPUT_ENABLE |=> reg_rdata_q[7:3] == 5'h00)
        else $error("reserved enable bits not zero");
    chk_readback: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `ADDR_AVERAGING_SAMPLING ##1 !reg_wr
        ##1 reg_rd && reg_addr == `ADDR_AVERAGING_SAMPLING && !reg_wr
        |=> reg_rdata_q == (8'h7F & $past(reg_wdata, 3)))
        else $error("averaging register readback wrong");
    chk_cycle_start: assert property (@(posedge clk) disable iff (rst)
        $rose(sampling_active_q) && $past(state_q, 1) == SEQ_IDLE |-> $past(start_due, 1))
        else $error("cycle started before cycle time");
endmodule
`default_nettype wire

// ### sim/sense_front_model.sv
/* Far-side sensor front end for the touch timing bench.
   Assumes the block's clock and its sampling outputs. */
`timescale 1ns/1ps
`default_nettype none
module sense_front_model (
    input wire logic clk,
    input wire logic sampling,
    input wire logic [1:0] channel,
    output logic [15:0] sample_value
);
    // ----------------------------------------
    // Sample source
    // ----------------------------------------
    logic [15:0] churn_q = 16'h0; // Idle pattern
    // Churn while idle so a stale value is never mistaken for a sample
    always @(posedge clk) begin
        churn_q <= churn_q + 16'h03B7;
    end
    // Fixed value per channel while sampling
    assign sample_value = sampling ? 16'h1000 + 16'h0111 * {14'h0, channel} : churn_q;
endmodule
`default_nettype wire

// ### sim/touch_timing_config_tb.sv
/* Self-checking bench for the touch timing configuration block.
   Assumes shortened counts: 20 cycles per ms, 4 cycles per base sample. */
`timescale 1ns/1ps
`default_nettype none
module touch_timing_config_tb;
    logic clk, rst, reg_wr, reg_rd, recal_en, sampling_active_q, meas_valid_q;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
    logic [2:0] rpt_en, touch, touch_ev, hold_ev, rpt_ev, recal_ev;
    logic [15:0] sample_value, meas_result_q;
    logic [1:0] sample_channel_q, meas_channel_q;
    int n_errors = 0, n_compared = 0, cycles = 0;
    int h_cnt, r_cnt, t_cnt, c_cnt, h_at, act;
    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    touch_timing_config #(.MS_CYCLES(20), .SAMPLE_BASE_CYCLES(4)) i_touch_timing_config (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .long_touch_recal_enable(recal_en), .repeat_enable(rpt_en),
        .touch_detect(touch), .sample_value(sample_value),
        .sampling_active_q(sampling_active_q), .sample_channel_q(sample_channel_q),
        .meas_valid_q(meas_valid_q), .meas_channel_q(meas_channel_q),
        .meas_result_q(meas_result_q), .touch_event_q(touch_ev),
        .hold_event_q(hold_ev), .repeat_event_q(rpt_ev), .recal_request_q(recal_ev));
    sense_front_model i_sense_front_model (.clk(clk), .sampling(sampling_active_q),
        .channel(sample_channel_q), .sample_value(sample_value));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t ns: got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // One idle edge so a following call never re-raises in this step
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({8'h0, reg_rdata_q}, {8'h0, exp});
        @(negedge clk);
    endtask
    // Next result pulse, counting sampling cycles on the way
    task automatic meas_wait();
        act = 0;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            if (meas_valid_q === 1'b1) break;
            if (sampling_active_q === 1'b1) act++;
        end
    endtask
    // Hold one input touched for n cycles and count its pulses
    task automatic touch_for(input int ch, input int n);
        {h_cnt, r_cnt, t_cnt, c_cnt, h_at} = '0;
        touch[ch] = 1'b1;
        for (int i = 1; i <= n + 8; i++) begin
            @(negedge clk);
            if (i == n) touch[ch] = 1'b0;
            if (hold_ev[ch] === 1'b1) h_at = i;
            h_cnt += int'(hold_ev[ch] === 1'b1);
            r_cnt += int'(rpt_ev[ch] === 1'b1);
            t_cnt += int'(touch_ev[ch] === 1'b1);
            c_cnt += int'(recal_ev[ch] === 1'b1);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic check_reset_values();
        rd_chk(8'h21, 8'h07);
        rd_chk(8'h22, 8'hA4);
        rd_chk(8'h23, 8'h07);
        rd_chk(8'h24, 8'h39);
        rd_chk(8'h25, 8'h00);
    endtask
    task automatic check_readback();
        wr(8'h21, 8'hFF);
        wr(8'h22, 8'h5C);
        wr(8'h23, 8'hF9);
        wr(8'h24, 8'hC0);
        rd_chk(8'h24, 8'h40);
        wr(8'h25, 8'hFF);
        rd_chk(8'h21, 8'h07);
        rd_chk(8'h22, 8'h5C);
        rd_chk(8'h23, 8'h09);
        rd_chk(8'h24, 8'h40);
        rd_chk(8'h25, 8'h00);
    endtask
    // Ascending enabled channels, sampling cycles, duration and average
    task automatic meas_run(input logic [2:0] en, input logic [7:0] cfg,
                            input logic [1:0] ch_a, input logic [1:0] ch_b, input int per);
        int t0;
        wr(8'h21, {5'h0, en});
        wr(8'h24, cfg);
        repeat (1500) @(negedge clk);
        // Always resync on a whole result so the next count starts clean
        for (int i = 0; i < 4; i++) begin
            meas_wait();
            if (meas_channel_q === ch_b) break;
        end
        meas_wait();
        t0 = cycles;
        chk(meas_channel_q, ch_a);
        chk(meas_result_q, 16'h1000 + 16'h0111 * ch_a);
        chk(act, per);
        meas_wait();
        chk(meas_channel_q, ch_b);
        chk(meas_result_q, 16'h1000 + 16'h0111 * ch_b);
        if (ch_a == ch_b) chk(cycles - t0 >= 700 && cycles - t0 <= 710, 1);
    endtask
    task automatic touch_scenarios();
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h00);
        rpt_en = 3'h7;
        touch_for(0, 1600);
        chk(h_cnt, 1);
        chk(h_at >= 700 && h_at <= 745, 1);
        chk(r_cnt, 1);
        chk(t_cnt, 0);
        touch_for(1, 400);
        chk({h_cnt[7:0], t_cnt[7:0]}, 16'h0001);
        rpt_en = 3'h0;
        touch_for(2, 1000);
        chk({h_cnt[7:0], t_cnt[7:0]}, 16'h0001);
        recal_en = 1'b1;
        touch_for(0, 11700);
        chk(c_cnt, 1);
        recal_en = 1'b0;
        touch_for(0, 11700);
        chk(c_cnt, 0);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, recal_en} = 3'h0;
        {reg_addr, reg_wdata, rpt_en, touch} = '0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        check_reset_values();
        check_readback();
        meas_run(3'h5, 8'h14, 2'd0, 2'd2, 16);
        meas_run(3'h2, 8'h00, 2'd1, 2'd1, 4);
        touch_scenarios();
        tally_and_finish();
    end
endmodule
`default_nettype wire
